// >>> rtl/supply_regs_defs.vh
/*
 * Constants of the supply register bank: register addresses, function
 * and exception codes, status bit positions, reset values and limits.
 * Assumes it is included by bare name from the bank's design file.
 */
`ifndef SUPPLY_REGS_DEFS_VH
`define SUPPLY_REGS_DEFS_VH

// Function codes
`define FC_READ        8'h03
`define FC_WRITE_ONE   8'h06
`define FC_WRITE_MANY  8'h10

// Exception codes
`define EXC_NONE       8'h00
`define EXC_FUNC       8'h01
`define EXC_ADDR       8'h02
`define EXC_VALUE      8'h03

// Register addresses
`define A_STATUS       16'h10D0
`define A_OUT_WR       16'h10F0
`define A_OUT_RD       16'h1100
`define A_MEAS_CURR    16'h2010
`define A_MEAS_VOLT    16'h2020
`define A_MEAS_PWR     16'h2030
`define A_CURR_WR      16'h3010
`define A_CURR_RD      16'h3020
`define A_VOLT_WR      16'h3030
`define A_VOLT_RD      16'h3040
`define A_PWR_WR       16'h3050
`define A_PWR_RD       16'h3060
`define A_TRIP_WR      16'h4010
`define A_TRIP_RD      16'h4020

// Register counts
`define CNT_ONE        16'h0001
`define CNT_TWO        16'h0002
`define CNT_STATUS     16'h0004

// Status word bit positions
`define SB_STANDBY     0
`define SB_LIVE        1
`define SB_CURR_TRIP   4
`define SB_SENSE_LOST  7
`define SB_LIN_OVERPWR 10
`define SB_RES_OVERPWR 11
`define SB_BOOT_FAIL   12
`define SB_BOOT_WAIT   13
`define SB_CURR_RATING 16
`define SB_VOLT_RATING 17
`define SB_AUX_FUSE    19
`define SB_REG_LOST    29
`define SB_UPDATING    30
`define SB_PHASE_MISS  32
`define SB_INPUT_FUSE  33
`define SB_FAN_STALL   34
`define SB_PWR_HOT     36
`define SB_FILTER_HOT  37
`define SB_XFMR_HOT    39

// Output enable values
`define OUT_OFF        16'h0000
`define OUT_ON         16'h0001

// Symbolic set-point values
`define SYM_MAX        32'hFFFF_FFFF
`define SYM_MIN        32'hFFFF_FFFE

// Float limits and reset values
`define FLT_ZERO       32'h0000_0000
`define FLT_INF        32'h7F80_0000
`define CURR_MAX       32'h4348_0000
`define VOLT_MAX       32'h447A_0000
`define PWR_MAX        32'h469C_4000
`define TRIP_MAX       32'h4370_0000

// Over-limit samples before a trip
`define TRIP_SAMPLES   3'h3

`endif

// >>> rtl/supply_regs.v
/*
 * Register bank of a programmable DC supply seen as a Modbus slave.
 * Assumes a link layer on clk_sys_i that strips framing and CRC, hands
 * over one decoded request at a time and takes register-wide answers.
 * Status flags, measurements and sample_i come from logic on the same
 * clock, so none of them is synchronised here.
 */
// What this block does
// - Status word is 64 bits; bit 0 standby, bit 1 output live.
// - Status bit 7 set while remote sense voltage is out of bounds.
// - Bit 10 linear module overpower, bit 11 resistor overpower.
// - Bit 12 target boot failed, bit 13 target still waiting to boot.
// - Bit 16 terminal current over rating, bit 17 voltage over rating.
// - Bit 19 auxiliary supply fuse blown, bit 33 input filter fuse.
// - Bit 29 out of regulation from unexpected currents.
// - Bit 32 input phase missing, bit 34 fan rotor locked.
// - Overheat bits: 36 power stage, 37 output filter, 39 transformer.
// - Bit 30 while controller updates other internal targets.
// - Single-register write 0x10F0, code 0x06: 1 on, 0 off.
// - Read 0x1100 gives 1 when processing power with no current trip, else 0.
// - Two-register read 0x2010, code 0x03: average current float.
// - Read 0x2020 gives voltage; sense terminals when remote sensing.
// - Read 0x2030 gives average terminal power float.
// - Current target written at 0x3010, code 0x10; read at 0x3020.
// - Voltage target written at 0x3030, read back at 0x3040.
// - Power target written at 0x3050, read back at 0x3060.
// - Targets accept zero to maximum, or symbolic minimum or maximum.
// - Trip limit 0x4010/0x4020; repeated overcurrent disables output.
// - Status is live and unlatched except bit 4, the held trip flag; reading clears nothing.
// - Status word read at 0x10D0 as four registers, code 0x03.
`include "supply_regs_defs.vh"

module supply_regs
(
  input  wire        clk_sys_i,
  input  wire        arst_n_i,
  // Decoded request from the link layer
  input  wire        req_valid_i,
  input  wire [7:0]  req_func_i,
  input  wire [15:0] req_addr_i,
  input  wire [15:0] req_count_i,
  input  wire [31:0] req_data_i,
  output reg         req_ready_o,
  // Answer, one register per beat
  output reg         rsp_valid_o,
  output reg  [15:0] rsp_data_o,
  output reg         rsp_last_o,
  output reg  [7:0]  rsp_exc_o,
  // Power stage state and measurements
  input  wire        power_active_i,
  input  wire        sense_remote_i,
  input  wire        sample_i,
  input  wire [31:0] meas_current_i,
  input  wire [31:0] meas_voltage_i,
  input  wire [31:0] sense_voltage_i,
  input  wire [31:0] meas_power_i,
  // Live condition flags
  input  wire        sense_line_lost_i,
  input  wire        linear_module_overpower_i,
  input  wire        resistor_overpower_i,
  input  wire        target_start_failed_i,
  input  wire        target_start_pending_i,
  input  wire        terminal_current_over_rating_i,
  input  wire        terminal_voltage_over_rating_i,
  input  wire        aux_supply_fuse_open_i,
  input  wire        regulation_lost_i,
  input  wire        subtarget_update_running_i,
  input  wire        input_phase_missing_i,
  input  wire        input_filter_fuse_open_i,
  input  wire        fan_stalled_i,
  input  wire        power_stage_overheat_i,
  input  wire        output_filter_overheat_i,
  input  wire        transformer_overheat_i,
  // Controls to the regulator
  output reg         output_enable_o,
  output reg  [31:0] current_target_o,
  output reg  [31:0] voltage_target_o,
  output reg  [31:0] power_target_o,
  output reg         current_trip_fault_o
);

  localparam S_IDLE = 1'b0;
  localparam S_SEND = 1'b1;

  reg        state_q;
  reg [63:0] shift_q;
  reg [2:0]  beats_q;
  reg [7:0]  exc_q;
  reg [31:0] trip_limit_q;
  reg [2:0]  over_cnt_q;

  // Positive float above limit; negative readings never exceed
  function flt_gt;
    input [31:0] a;
    input [31:0] b;
    begin
      flt_gt = !a[31] && (b[31] || (a[30:0] > b[30:0]));
    end
  endfunction

  // Range check for a written target, symbolic codes let through
  function tgt_ok;
    input [31:0] v;
    input [31:0] max;
    begin
      tgt_ok = (v == `SYM_MAX) || (v == `SYM_MIN) ||
               (!v[31] && !flt_gt(v, max));
    end
  endfunction

  // Resolve symbolic minimum and maximum to stored values
  function [31:0] tgt_val;
    input [31:0] v;
    input [31:0] max;
    begin
      if (v == `SYM_MAX)
        tgt_val = max;
      else if (v == `SYM_MIN)
        tgt_val = `FLT_ZERO;
      else
        tgt_val = v;
    end
  endfunction

  // Live status word; positions not driven stay zero
  reg [63:0] status_w;
  always @*
  begin
    status_w = 64'h0000_0000_0000_0000;
    status_w[`SB_STANDBY]     = !power_active_i;
    status_w[`SB_LIVE]        = power_active_i;
    status_w[`SB_CURR_TRIP]   = current_trip_fault_o;
    status_w[`SB_SENSE_LOST]  = sense_line_lost_i;
    status_w[`SB_LIN_OVERPWR] = linear_module_overpower_i;
    status_w[`SB_RES_OVERPWR] = resistor_overpower_i;
    status_w[`SB_BOOT_FAIL]   = target_start_failed_i;
    status_w[`SB_BOOT_WAIT]   = target_start_pending_i;
    status_w[`SB_CURR_RATING] = terminal_current_over_rating_i;
    status_w[`SB_VOLT_RATING] = terminal_voltage_over_rating_i;
    status_w[`SB_AUX_FUSE]    = aux_supply_fuse_open_i;
    status_w[`SB_INPUT_FUSE]  = input_filter_fuse_open_i;
    status_w[`SB_REG_LOST]    = regulation_lost_i;
    status_w[`SB_PHASE_MISS]  = input_phase_missing_i;
    status_w[`SB_FAN_STALL]   = fan_stalled_i;
    status_w[`SB_PWR_HOT]     = power_stage_overheat_i;
    status_w[`SB_FILTER_HOT]  = output_filter_overheat_i;
    status_w[`SB_XFMR_HOT]    = transformer_overheat_i;
    status_w[`SB_UPDATING]    = subtarget_update_running_i;
  end

  // Request decode: answer image, beat count and exception code
  reg [63:0] img_w;
  reg [2:0]  nbeat_w;
  reg [7:0]  exc_w;
  reg        wr_out_w;
  reg        wr_curr_w;
  reg        wr_volt_w;
  reg        wr_pwr_w;
  reg        wr_trip_w;
  reg [15:0] rd_cnt_w;
  always @*
  begin
    img_w     = 64'h0000_0000_0000_0000;
    nbeat_w   = 3'h1;
    exc_w     = `EXC_NONE;
    wr_out_w  = 1'b0;
    wr_curr_w = 1'b0;
    wr_volt_w = 1'b0;
    wr_pwr_w  = 1'b0;
    wr_trip_w = 1'b0;
    rd_cnt_w  = `CNT_TWO;
    case (req_func_i)
      `FC_READ:
      begin
        // Image is left aligned so the high register leaves first
        case (req_addr_i)
          `A_STATUS:
          begin
            img_w    = status_w;
            rd_cnt_w = `CNT_STATUS;
          end
          `A_OUT_RD:
          begin
            img_w[48] = power_active_i && !current_trip_fault_o;
            rd_cnt_w  = `CNT_ONE;
          end
          `A_MEAS_CURR: img_w[63:32] = meas_current_i;
          `A_MEAS_VOLT: img_w[63:32] = sense_remote_i ?
                          sense_voltage_i : meas_voltage_i;
          `A_MEAS_PWR:  img_w[63:32] = meas_power_i;
          `A_CURR_RD:   img_w[63:32] = current_target_o;
          `A_VOLT_RD:   img_w[63:32] = voltage_target_o;
          `A_PWR_RD:    img_w[63:32] = power_target_o;
          `A_TRIP_RD:   img_w[63:32] = trip_limit_q;
          default:      exc_w = `EXC_ADDR;
        endcase
        // Only the whole value is served, never a part of it
        if (exc_w == `EXC_NONE && req_count_i != rd_cnt_w)
          exc_w = `EXC_ADDR;
        if (exc_w == `EXC_NONE)
          nbeat_w = rd_cnt_w[2:0];
      end
      `FC_WRITE_ONE:
      begin
        if (req_addr_i != `A_OUT_WR)
          exc_w = `EXC_ADDR;
        else if (req_data_i[15:0] != `OUT_ON &&
                 req_data_i[15:0] != `OUT_OFF)
          exc_w = `EXC_VALUE;
        else
          wr_out_w = 1'b1;
      end
      `FC_WRITE_MANY:
      begin
        if (req_count_i != `CNT_TWO)
          exc_w = `EXC_ADDR;
        else
        begin
          // req_data_i[31:16] is the first, high register
          case (req_addr_i)
            `A_CURR_WR:
            begin
              wr_curr_w = tgt_ok(req_data_i, `CURR_MAX);
              exc_w = wr_curr_w ? `EXC_NONE : `EXC_VALUE;
            end
            `A_VOLT_WR:
            begin
              wr_volt_w = tgt_ok(req_data_i, `VOLT_MAX);
              exc_w = wr_volt_w ? `EXC_NONE : `EXC_VALUE;
            end
            `A_PWR_WR:
            begin
              wr_pwr_w = tgt_ok(req_data_i, `PWR_MAX);
              exc_w = wr_pwr_w ? `EXC_NONE : `EXC_VALUE;
            end
            `A_TRIP_WR:
            begin
              wr_trip_w = tgt_ok(req_data_i, `TRIP_MAX);
              exc_w = wr_trip_w ? `EXC_NONE : `EXC_VALUE;
            end
            default: exc_w = `EXC_ADDR;
          endcase
        end
      end
      default: exc_w = `EXC_FUNC;
    endcase
  end

  wire take_w = req_valid_i && req_ready_o;

  // Trip detection on consecutive over-limit samples
  wire over_w = flt_gt(meas_current_i, trip_limit_q);
  wire trip_w = sample_i && over_w &&
                (over_cnt_q == `TRIP_SAMPLES - 3'h1);

  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      over_cnt_q <= 3'h0;
    else if (sample_i)
    begin
      if (!over_w)
        over_cnt_q <= 3'h0;
      else if (over_cnt_q != `TRIP_SAMPLES)
        over_cnt_q <= over_cnt_q + 3'h1;
    end
  end

  // Output enable and trip flag; a trip in the same cycle beats a write
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      output_enable_o      <= 1'b0;
      current_trip_fault_o <= 1'b0;
    end
    else if (trip_w)
    begin
      output_enable_o      <= 1'b0;
      current_trip_fault_o <= 1'b1;
    end
    else if (take_w && wr_out_w)
    begin
      output_enable_o <= req_data_i[0];
      // Switching on again is the acknowledgement of a trip
      if (req_data_i[0])
        current_trip_fault_o <= 1'b0;
    end
  end

  // Targets and trip limit; infinite limit never trips after reset
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      current_target_o <= `FLT_ZERO;
      voltage_target_o <= `FLT_ZERO;
      power_target_o   <= `FLT_ZERO;
      trip_limit_q     <= `FLT_INF;
    end
    else if (take_w)
    begin
      if (wr_curr_w)
        current_target_o <= tgt_val(req_data_i, `CURR_MAX);
      if (wr_volt_w)
        voltage_target_o <= tgt_val(req_data_i, `VOLT_MAX);
      if (wr_pwr_w)
        power_target_o <= tgt_val(req_data_i, `PWR_MAX);
      if (wr_trip_w)
        trip_limit_q <= tgt_val(req_data_i, `TRIP_MAX);
    end
  end

  // Answer sequencer; the image is frozen at take so a multi-beat
  // value is coherent even if the source changes mid-answer
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q     <= S_IDLE;
      shift_q     <= 64'h0000_0000_0000_0000;
      beats_q     <= 3'h0;
      exc_q       <= `EXC_NONE;
      req_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 16'h0000;
      rsp_last_o  <= 1'b0;
      rsp_exc_o   <= `EXC_NONE;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          rsp_valid_o <= 1'b0;
          rsp_last_o  <= 1'b0;
          if (take_w)
          begin
            state_q     <= S_SEND;
            req_ready_o <= 1'b0;
            shift_q     <= img_w;
            beats_q     <= nbeat_w;
            exc_q       <= exc_w;
          end
        end
        S_SEND:
        begin
          rsp_valid_o <= 1'b1;
          rsp_data_o  <= shift_q[63:48];
          rsp_exc_o   <= exc_q;
          rsp_last_o  <= (beats_q == 3'h1);
          shift_q     <= {shift_q[47:0], 16'h0000};
          beats_q     <= beats_q - 3'h1;
          if (beats_q == 3'h1)
          begin
            state_q     <= S_IDLE;
            req_ready_o <= 1'b1;
          end
        end
        default:
        begin
          state_q     <= S_IDLE;
          req_ready_o <= 1'b1;
        end
      endcase
    end
  end

endmodule // supply_regs

// >>> bench/supply_regs_assertions.sv
/* Checker of the supply register bank: answer timing, beat counts,
   output control and trip. Assumes one clock and async low reset. */
module supply_regs_chk (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        req_valid_i,
  input wire logic [7:0]  req_func_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_count_i,
  input wire logic [31:0] req_data_i,
  input wire logic        req_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_last_o,
  input wire logic [7:0]  rsp_exc_o,
  input wire logic        output_enable_o,
  input wire logic        current_trip_fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Requests taken at this edge, by kind
  wire tk   = req_valid_i && req_ready_o;
  wire rd   = tk && req_func_i == 8'h03;
  wire wone = tk && req_func_i == 8'h06 && req_addr_i == 16'h10F0;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_take_busy: assert property (tk |=> !req_ready_o ##1 rsp_valid_o)
    else $error("no answer after take");
  a_last_free: assert property (rsp_valid_o && rsp_last_o |->
    req_ready_o ##1 !rsp_valid_o) else $error("last beat");
  a_status_beats: assert property (rd && req_addr_i == 16'h10D0 &&
    req_count_i == 16'h0004 |=> ##1 (rsp_valid_o && !rsp_last_o) [*3]
    ##1 rsp_last_o) else $error("status not four beats");
  a_float_beats: assert property (rd && req_addr_i == 16'h2010 &&
    req_count_i == 16'h0002 |=> ##1 !rsp_last_o ##1 rsp_last_o)
    else $error("float not two beats");
  a_output_on: assert property (wone && req_data_i[15:0] == 16'h0001
    |=> output_enable_o) else $error("output not on");
  a_output_off: assert property (wone && req_data_i[15:0] == 16'h0000
    |=> !output_enable_o) else $error("output not off");
  a_trip_off: assert property ($rose(current_trip_fault_o) |->
    !output_enable_o) else $error("trip left output on");
  a_bad_func: assert property (tk && !(req_func_i inside {8'h03,
    8'h06, 8'h10}) |=> ##1 rsp_last_o && rsp_exc_o == 8'h01)
    else $error("bad function accepted");
  // Main scenarios seen
  c_read: cover property (rd);
  c_trip: cover property ($rose(current_trip_fault_o));
  c_exc: cover property (rsp_valid_o && rsp_exc_o != 8'h00);
endmodule // supply_regs_chk

bind supply_regs supply_regs_chk chk (.*);

// >>> bench/mb_master.sv
/* Master model: one decoded request at a time, beats kept in order.
   Assumes the bank answers on the same clock. */
module mb_master (
  input  wire logic        clk_i,
  input  wire logic        rv_i,
  input  wire logic        last_i,
  input  wire logic [15:0] rd_i,
  input  wire logic [7:0]  exc_i,
  output logic             valid_o,
  output logic [7:0]       func_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      cnt_o,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] beat [4];
  logic [7:0]  exc;
  int          n;
  // Idle bus from time zero
  initial
  begin
    valid_o = 1'b0;
    {func_o, addr_o, cnt_o, data_o} = '0;
  end
  // One value per request; held over the taking edge only
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, c,
                      input logic [31:0] d);
    @(negedge clk_i);
    {valid_o, func_o, addr_o, cnt_o, data_o} = {1'b1, f, a, c, d};
    @(posedge clk_i);
    // Release off the sampling edge, like every other bench input
    @(negedge clk_i);
    valid_o = 1'b0;
    {addr_o, data_o} = ~{a, d}; // Released address and data lines show no stale value
    n = 0;
    exc = 8'h00;
    // Bounded wait; beats stored high register first
    for (int t = 0; t < 8; t++)
    begin
      @(negedge clk_i);
      if (rv_i)
      begin
        beat[n[1:0]] = rd_i;
        exc = exc_i;
        n++;
        if (last_i)
          break;
      end
    end
  endtask
endmodule // mb_master

// >>> bench/supply_regs_tb.sv
/* Self-checking bench of the supply register bank.
   Assumes mb_master as the far side and the checker bound in. */
`include "supply_regs_defs.vh"
module supply_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, sample_i = 1'b0;
  logic        power_active_i = 1'b0, sense_remote_i = 1'b0;
  logic [31:0] meas_current_i = 32'h4049_0FDB;
  logic [31:0] meas_voltage_i = 32'h4248_0000;
  logic [31:0] sense_voltage_i = 32'h4250_0000;
  logic [31:0] meas_power_i = 32'h4480_0000;
  logic [15:0] fl = 16'h0000;
  logic [63:0] all;
  wire         req_valid_i, req_ready_o, rsp_valid_o, rsp_last_o;
  wire  [7:0]  req_func_i, rsp_exc_o;
  wire  [15:0] req_addr_i, req_count_i, rsp_data_o;
  wire  [31:0] req_data_i, current_target_o, voltage_target_o;
  wire  [31:0] power_target_o;
  wire         output_enable_o, current_trip_fault_o;
  // Condition flags, one bit of fl each
  wire sense_line_lost_i = fl[0], linear_module_overpower_i = fl[1],
    resistor_overpower_i = fl[2], target_start_failed_i = fl[3],
    target_start_pending_i = fl[4],
    terminal_current_over_rating_i = fl[5],
    terminal_voltage_over_rating_i = fl[6],
    aux_supply_fuse_open_i = fl[7], regulation_lost_i = fl[8],
    subtarget_update_running_i = fl[9], input_phase_missing_i = fl[10],
    input_filter_fuse_open_i = fl[11], fan_stalled_i = fl[12],
    power_stage_overheat_i = fl[13], output_filter_overheat_i = fl[14],
    transformer_overheat_i = fl[15];
  int pos [16] = '{7, 10, 11, 12, 13, 16, 17, 19, 29, 30, 32, 33, 34,
                   36, 37, 39};
  logic [15:0] wa [3] = '{16'h3010, 16'h3030, 16'h3050};
  logic [31:0] mx [3] = '{`CURR_MAX, `VOLT_MAX, `PWR_MAX};
  int errors = 0;
  int comparisons = 0;

  supply_regs uut (.*);
  mb_master m (.clk_i(clk_sys_i), .rv_i(rsp_valid_o),
    .last_i(rsp_last_o), .rd_i(rsp_data_o), .exc_i(rsp_exc_o),
    .valid_o(req_valid_i), .func_o(req_func_i), .addr_o(req_addr_i),
    .cnt_o(req_count_i), .data_o(req_data_i));

  always #25 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string s, input logic [63:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // Read and pack the beats in arrival order
  task automatic rdc(input string s, input logic [15:0] a, c,
                     input logic [63:0] e);
    logic [63:0] r;
    r = '0;
    m.xfer(`FC_READ, a, c, 32'h0000_0000);
    for (int i = 0; i < m.n; i++)
      r = {r[47:0], m.beat[i]};
    chk(s, e, r);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [7:0] e);
    logic one;
    one = (a == `A_OUT_WR);
    m.xfer(one ? `FC_WRITE_ONE : `FC_WRITE_MANY, a,
           one ? `CNT_ONE : `CNT_TWO, d);
    chk("exception", e, m.exc);
  endtask
  task automatic pulse(input logic [31:0] v);
    @(negedge clk_sys_i);
    meas_current_i = v;
    sample_i = 1'b1;
    @(negedge clk_sys_i);
    sample_i = 1'b0;
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: tests need about 300 cycles
  initial
  begin
    #400_000;
    errors++;
    test_done;
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    all = 64'h1;
    for (int i = 0; i < 16; i++)
    begin
      fl = 16'h0001 << i;
      all |= 64'h1 << pos[i];
      rdc("status", `A_STATUS, `CNT_STATUS,
          (64'h1 << pos[i]) | 64'h1);
    end
    fl = 16'hFFFF;
    repeat (2) rdc("status all", `A_STATUS, `CNT_STATUS, all);
    fl = 16'h0000;
    $display("done status");
    rdc("current", `A_MEAS_CURR, `CNT_TWO, 64'h4049_0FDB);
    rdc("voltage", `A_MEAS_VOLT, `CNT_TWO, 64'h4248_0000);
    sense_remote_i = 1'b1;
    rdc("sense", `A_MEAS_VOLT, `CNT_TWO, 64'h4250_0000);
    rdc("power", `A_MEAS_PWR, `CNT_TWO, 64'h4480_0000);
    $display("done measure");
    for (int i = 0; i < 3; i++)
    begin
      wr(wa[i], 32'h40A0_0000, `EXC_NONE);
      rdc("target", wa[i] + 16'h0010, `CNT_TWO, 64'h40A0_0000);
      wr(wa[i], `SYM_MAX, `EXC_NONE);
      rdc("max", wa[i] + 16'h0010, `CNT_TWO, {32'h0, mx[i]});
      wr(wa[i], `SYM_MIN, `EXC_NONE);
      wr(wa[i], mx[i] + 32'h1, `EXC_VALUE);
      wr(wa[i], 32'hBF80_0000, `EXC_VALUE);
      rdc("min", wa[i] + 16'h0010, `CNT_TWO, 64'h0);
    end
    // Refused writes must leave the targets untouched
    m.xfer(`FC_WRITE_MANY, `A_CURR_WR, `CNT_ONE, 32'h40A0_0000);
    chk("write count", `EXC_ADDR, m.exc);
    m.xfer(`FC_WRITE_MANY, `A_CURR_RD, `CNT_TWO, 32'h40A0_0000);
    chk("write target addr", `EXC_ADDR, m.exc);
    m.xfer(`FC_WRITE_ONE, `A_OUT_RD, `CNT_ONE, 32'h0000_0001);
    chk("write one addr", `EXC_ADDR, m.exc);
    chk("targets", 64'h0,
        {current_target_o, voltage_target_o | power_target_o});
    $display("done targets");
    power_active_i = 1'b1;
    wr(`A_OUT_WR, 32'h1, `EXC_NONE);
    chk("enable", 64'h1, output_enable_o);
    rdc("state", `A_OUT_RD, `CNT_ONE, 64'h1);
    wr(`A_OUT_WR, 32'h2, `EXC_VALUE);
    m.xfer(8'h04, `A_OUT_RD, `CNT_ONE, 32'h0);
    chk("bad function", `EXC_FUNC, m.exc);
    m.xfer(`FC_READ, `A_MEAS_CURR, `CNT_ONE, 32'h0);
    chk("bad count", `EXC_ADDR, m.exc);
    m.xfer(`FC_READ, 16'h1234, `CNT_TWO, 32'h0);
    chk("unmapped", `EXC_ADDR, m.exc);
    wr(`A_OUT_WR, 32'h0, `EXC_NONE);
    chk("disable", 64'h0, output_enable_o);
    $display("done output");
    // A low sample breaks the run of over-limit samples
    wr(`A_TRIP_WR, 32'h4120_0000, `EXC_NONE);
    rdc("limit", `A_TRIP_RD, `CNT_TWO, 64'h4120_0000);
    wr(`A_OUT_WR, 32'h1, `EXC_NONE);
    repeat (2) pulse(32'h4140_0000);
    pulse(32'h40A0_0000);
    repeat (2) pulse(32'h4140_0000);
    chk("no trip", 64'h1, {current_trip_fault_o, output_enable_o});
    pulse(32'h4140_0000);
    @(negedge clk_sys_i);
    chk("trip", 64'h2, {current_trip_fault_o, output_enable_o});
    rdc("status trip", `A_STATUS, `CNT_STATUS, 64'h12);
    rdc("state trip", `A_OUT_RD, `CNT_ONE, 64'h0);
    wr(`A_OUT_WR, 32'h1, `EXC_NONE);
    chk("restart", 64'h1, {current_trip_fault_o, output_enable_o});
    $display("done trip");
    test_done;
  end
endmodule // supply_regs_tb
